//--- hw/clk_ctrl_pkg.sv
/*
 clock-control slice constants: register offsets, field positions,
 reset values, command codes and cycle counts.
 assumes a 32-bit apb slave with one register per aligned word.
*/
package clk_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DIVIDER  = 8'h00;
  localparam logic [7:0] ADDR_TRIM     = 8'h04;
  localparam logic [7:0] ADDR_COMMAND  = 8'h08;
  localparam logic [7:0] ADDR_WDOG     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int UNLOCK_BIT      = 7;
  localparam int WD_RST_EN_BIT   = 3;
  localparam int WD_IRQ_EN_BIT   = 4;
  localparam int WD_UNLOCK_BIT   = 7;

  // ----------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
  localparam logic [3:0] DIV_RESET_FUSE  = 4'h3;
  localparam logic [3:0] DIV_CODE_MAX    = 4'h8;
  localparam logic [3:0] CMD_WD_AUTO     = 4'h6;
  localparam logic [3:0] WD_PERIOD_RESET = 4'h0;
  localparam logic [2:0] UNLOCK_CYCLES   = 3'h4;
  localparam int         WD_BASE_CYCLES  = 2048;

endpackage

//--- hw/clk_divider.sv
/*
 glitch-free power-of-two clock divider.
 assumes clk is the undivided source; code is a legal code 0..8.
*/
`timescale 1ns/10ps
module clk_divider
  import clk_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] code,
  output logic            clk_en,
  output logic [3:0]      active_code
);

  logic [7:0] count_q;
  logic [7:0] mask;

  // ----------------------------------------------------------------------
  // free-running count, never visible to software
  // ----------------------------------------------------------------------
  function automatic logic [7:0] mask_of(input logic [3:0] c);
    mask_of = 8'(9'h1FF >> (4'h9 - c));
  endfunction

  assign mask = mask_of(active_code);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_q + 8'h01; // RULE11
    end
  end

  // ----------------------------------------------------------------------
  // a new code is adopted only at the end of the current period
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_code <= DIV_RESET_PLAIN;
    end else if ((count_q & mask) == mask) begin
      active_code <= code; // RULE10 RULE12
    end
  end

  // one-cycle enable per divided period drives cpu, flash, io and adc
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en <= 1'b0;
    end else begin
      clk_en <= ((count_q & mask) == mask); // RULE9
    end
  end

endmodule

//--- hw/wdog_auto.sv
/*
 watchdog in automatic-reload mode: counts watchdog ticks and resets.
 assumes wd_tick is a synchronised watchdog-oscillator pulse.
*/
`timescale 1ns/10ps
module wdog_auto
  import clk_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       active,
  input  wire logic       kick,
  input  wire logic       wd_tick,
  input  wire logic [3:0] period,
  output logic            timeout
);

  logic [20:0] count_q;
  logic [20:0] limit;

  assign limit = 21'(WD_BASE_CYCLES) << period[2:0]; // RULE4

  // ----------------------------------------------------------------------
  // timeout counter, reloaded by hardware while the system clock runs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 21'h000000;
      timeout <= 1'b0;
    end else if (!active || kick) begin
      count_q <= 21'h000000;
      timeout <= 1'b0;
    end else if (wd_tick) begin
      count_q <= count_q + 21'h000001;
      timeout <= (count_q + 21'h000001) >= limit; // RULE3
    end
  end

endmodule

//--- hw/clk_ctrl.sv
/*
 clock prescaler, rc trim, clock command unlock and automatic-reload
 watchdog, behind an apb slave.
 assumes pclk is the undivided source clock and presetn the chip reset;
 fuse and watchdog tick inputs come from outside and are synchronised.
*/
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
//Contract
// RULE1 - auto-reload watchdog command overrides normal watchdog enable.
// RULE2 - auto-reload command is clock command code 0110.
// RULE3 - in auto-reload mode watchdog only resets, never interrupts.
// RULE4 - auto-reload timeout still uses watchdog period select field.
// RULE5 - auto-reload stays active until any reset clears it.
// RULE6 - monitoring holds only for clocks at least 4x watchdog clock.
// RULE7 - software should enable auto-reload before external clock switch.
// RULE8 - use auto-reload only when reset clock source is internal.
// RULE9 - divider output drives cpu, flash, io and adc clocks.
// RULE10 - divider changes are glitch free, no shorter intermediate period.
// RULE11 - divider is a counter on source clock, count not readable.
// RULE12 - new rate active within old plus one to two new periods.
// RULE13 - trim loads factory value at reset, writes retune oscillator.
// RULE14 - top trim bit selects low or high overlapping range.
// RULE15 - lower seven trim bits tune monotonically within range.
// RULE16 - unlock bit set only by write with all other bits zero.
// RULE17 - unlock clears four cycles after set or on code write.
// RULE18 - rewriting unlock while set neither restarts nor clears it.
// RULE19 - new code accepted only within four cycles with unlock zero.
// RULE20 - software keeps interrupts off during divider change sequence.
// RULE21 - code resets to 0000, or 0011 with divide-by-eight fuse.
// RULE22 - any code may be written after reset regardless of fuse.
// RULE23 - code n divides by 2^n for 0..8; 9..15 reserved.
// RULE24 - divider bits 6:4 ignore writes and read zero.
// RULE25 - reserved code is stored but previous factor kept.
module clk_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = 8'h80
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        divide_by_eight_fuse,
  input  wire logic        wd_osc_tick,
  output logic             sys_clk_en,
  output logic [7:0]       rc_trim_out,
  output logic             wdog_reset_req,
  output logic             wdog_irq
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic       wr;
  logic       hit;
  logic       sel_div;
  logic       sel_trim;
  logic       sel_cmd;
  logic       sel_wdog;
  logic [31:0] rdata_d;
  logic [7:0] wbyte;
  logic       fuse_s1_q;
  logic       fuse_s2_q;
  logic       tick_s1_q;
  logic       tick_s2_q;
  logic       tick_d1_q;
  logic       tick_pulse;
  logic       strap_done_q;
  logic       div_unlock_q;
  logic [2:0] div_win_q;
  logic [3:0] division_code_q;
  logic [3:0] effective_code_q;
  logic [3:0] active_code;
  logic       cmd_unlock_q;
  logic [2:0] cmd_win_q;
  logic [3:0] clock_command_code_q;
  logic       auto_reload_q;
  logic [7:0] rc_oscillator_trim_q;
  logic       wd_reset_enable_q;
  logic       wd_irq_enable_q;
  logic       wd_unlock_q;
  logic [2:0] wd_win_q;
  logic [3:0] wd_period_q;
  logic       auto_timeout;
  logic       std_timeout_q;
  logic [20:0] std_count_q;

  function automatic logic legal_code(input logic [3:0] c);
    legal_code = (c <= DIV_CODE_MAX);
  endfunction

  // watchdog timeout length in ticks for a period select value
  function automatic logic [20:0] wd_limit(input logic [3:0] p);
    wd_limit = 21'(WD_BASE_CYCLES) << p[2:0];
  endfunction

  // ----------------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------------
  assign pready  = 1'b1;
  assign sel_div  = (paddr == ADDR_DIVIDER);
  assign sel_trim = (paddr == ADDR_TRIM);
  assign sel_cmd  = (paddr == ADDR_COMMAND);
  assign sel_wdog = (paddr == ADDR_WDOG);
  assign hit      = sel_div || sel_trim || sel_cmd || sel_wdog
                 || (paddr == ADDR_STATUS);
  assign pslverr  = psel && penable && !hit;
  assign wr       = psel && penable && pwrite && hit;
  assign wbyte    = pwdata[7:0];

  // read mux, captured in the setup cycle
  always_comb begin
    rdata_d = 32'h00000000;
    case (paddr)
      ADDR_DIVIDER: begin
        rdata_d = {24'h000000, div_unlock_q, 3'h0,
                   division_code_q}; // RULE24 RULE11
      end
      ADDR_TRIM: begin
        rdata_d = {24'h000000, rc_oscillator_trim_q};
      end
      ADDR_COMMAND: begin
        rdata_d = {24'h000000, cmd_unlock_q, 3'h0,
                   clock_command_code_q};
      end
      ADDR_WDOG: begin
        rdata_d = {24'h000000, wd_unlock_q, 2'h0, wd_irq_enable_q,
                   wd_reset_enable_q, wd_period_q[2:0]};
      end
      ADDR_STATUS: begin
        rdata_d = {24'h000000, 3'h0, auto_reload_q, active_code};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // fuse chain has no reset, so it holds the fuse level at release
  always_ff @(posedge pclk) begin
    fuse_s1_q <= divide_by_eight_fuse;
    fuse_s2_q <= fuse_s1_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_d1_q <= 1'b0;
    end else begin
      tick_s1_q <= wd_osc_tick;
      tick_s2_q <= tick_s1_q;
      tick_d1_q <= tick_s2_q;
    end
  end

  assign tick_pulse = tick_s2_q && !tick_d1_q;

  // ----------------------------------------------------------------------
  // divider unlock window
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_unlock_q <= 1'b0;
      div_win_q    <= 3'h0;
    end else if (wr && paddr == ADDR_DIVIDER && !wbyte[UNLOCK_BIT]) begin
      div_unlock_q <= 1'b0; // RULE17
      div_win_q    <= 3'h0;
    end else if (div_unlock_q) begin
      div_win_q    <= div_win_q - 3'h1; // RULE18
      div_unlock_q <= (div_win_q != 3'h1); // RULE17
    end else if (wr && paddr == ADDR_DIVIDER && wbyte == 8'h80) begin
      div_unlock_q <= 1'b1; // RULE16
      div_win_q    <= UNLOCK_CYCLES;
    end
  end

  // ----------------------------------------------------------------------
  // division code, strapped from the fuse just after reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q     <= 1'b0;
      division_code_q  <= DIV_RESET_PLAIN;
      effective_code_q <= DIV_RESET_PLAIN;
    end else if (!strap_done_q) begin
      // fuse level was sampled while reset was held
      strap_done_q     <= 1'b1;
      division_code_q  <= fuse_s2_q ? DIV_RESET_FUSE
                                    : DIV_RESET_PLAIN; // RULE21
      effective_code_q <= fuse_s2_q ? DIV_RESET_FUSE : DIV_RESET_PLAIN;
    end else if (wr && paddr == ADDR_DIVIDER && div_unlock_q
                 && !wbyte[UNLOCK_BIT]) begin
      division_code_q <= wbyte[3:0]; // RULE19 RULE22
      if (legal_code(wbyte[3:0])) begin
        effective_code_q <= wbyte[3:0]; // RULE23 RULE25
      end
    end
  end

  clk_divider u_div (
    .clk         (pclk),
    .rst_n       (presetn),
    .code        (effective_code_q),
    .clk_en      (sys_clk_en),
    .active_code (active_code)
  );

  // ----------------------------------------------------------------------
  // rc oscillator trim
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_oscillator_trim_q <= FACTORY_TRIM; // RULE13
    end else if (wr && paddr == ADDR_TRIM) begin
      rc_oscillator_trim_q <= wbyte; // RULE13
    end
  end

  // range bit and fine value go straight to the oscillator
  assign rc_trim_out = rc_oscillator_trim_q; // RULE14 RULE15

  // ----------------------------------------------------------------------
  // clock command register with its own unlock window
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_unlock_q         <= 1'b0;
      cmd_win_q            <= 3'h0;
      clock_command_code_q <= 4'h0;
    end else if (wr && paddr == ADDR_COMMAND && !wbyte[UNLOCK_BIT]) begin
      if (cmd_unlock_q) begin
        clock_command_code_q <= wbyte[3:0];
      end
      cmd_unlock_q <= 1'b0;
      cmd_win_q    <= 3'h0;
    end else if (cmd_unlock_q) begin
      cmd_win_q    <= cmd_win_q - 3'h1;
      cmd_unlock_q <= (cmd_win_q != 3'h1);
    end else if (wr && paddr == ADDR_COMMAND && wbyte == 8'h80) begin
      cmd_unlock_q <= 1'b1;
      cmd_win_q    <= UNLOCK_CYCLES;
    end
  end

  // ----------------------------------------------------------------------
  // auto-reload mode, cleared only by reset
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_reload_q <= 1'b0; // RULE5
    end else if (wr && paddr == ADDR_COMMAND && cmd_unlock_q
                 && !wbyte[UNLOCK_BIT] && wbyte[3:0] == CMD_WD_AUTO) begin
      auto_reload_q <= 1'b1; // RULE2
    end
  end

  // ----------------------------------------------------------------------
  // watchdog control
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_unlock_q       <= 1'b0;
      wd_win_q          <= 3'h0;
      wd_reset_enable_q <= 1'b0;
      wd_irq_enable_q   <= 1'b0;
      wd_period_q       <= WD_PERIOD_RESET;
    end else if (wr && paddr == ADDR_WDOG) begin
      wd_period_q     <= {1'b0, wbyte[2:0]};
      wd_irq_enable_q <= wbyte[WD_IRQ_EN_BIT];
      if (wd_unlock_q || wbyte[WD_RST_EN_BIT]) begin
        wd_reset_enable_q <= wbyte[WD_RST_EN_BIT];
      end
      wd_unlock_q <= wbyte[WD_UNLOCK_BIT] && wbyte[WD_RST_EN_BIT];
      wd_win_q    <= UNLOCK_CYCLES;
    end else if (wd_unlock_q) begin
      wd_win_q    <= wd_win_q - 3'h1;
      wd_unlock_q <= (wd_win_q != 3'h1);
    end
  end

  // ----------------------------------------------------------------------
  // standard mode: software kicks by writing the control register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_count_q   <= 21'h000000;
      std_timeout_q <= 1'b0;
    end else if (auto_reload_q || (wr && paddr == ADDR_WDOG)) begin
      std_count_q   <= 21'h000000; // RULE1
      std_timeout_q <= 1'b0;
    end else if (tick_pulse && (wd_reset_enable_q || wd_irq_enable_q))
    begin
      std_count_q   <= std_count_q + 21'h000001;
      std_timeout_q <= (std_count_q + 21'h000001)
                       >= wd_limit(wd_period_q);
    end
  end

  // ----------------------------------------------------------------------
  // hardware reload while the system clock is ticking
  // ----------------------------------------------------------------------
  // a kick landing on a tick is dropped, so a clock too slow still counts
  wdog_auto u_wd (
    .clk     (pclk),
    .rst_n   (presetn),
    .active  (auto_reload_q),
    .kick    (sys_clk_en && !tick_pulse), // RULE6
    .wd_tick (tick_pulse),
    .period  (wd_period_q),
    .timeout (auto_timeout)
  );

  // ----------------------------------------------------------------------
  // watchdog outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_reset_req <= 1'b0;
      wdog_irq       <= 1'b0;
    end else begin
      wdog_reset_req <= auto_reload_q ? auto_timeout
                      : (std_timeout_q && wd_reset_enable_q); // RULE1
      wdog_irq       <= !auto_reload_q && std_timeout_q
                        && wd_irq_enable_q; // RULE3
    end
  end

endmodule

//--- bench/clk_ctrl_chk.sv
/*
 checker for clk_ctrl: reads, trim, divider lock, clock enable spacing
 and auto-reload watchdog.
 assumes it is bound onto clk_ctrl and sees only that module's ports.
*/
`timescale 1ns/10ps
module clk_ctrl_chk
  import clk_ctrl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        divide_by_eight_fuse,
  input wire logic        wd_osc_tick,
  input wire logic        sys_clk_en,
  input wire logic [7:0]  rc_trim_out,
  input wire logic        wdog_reset_req,
  input wire logic        wdog_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // helper state
  // ----------------
  logic       acc_w;
  logic       acc_r;
  logic [7:0] wbyte;
  logic [2:0] win_q;
  logic       auto_q;
  logic [3:0] since_q;
  logic [9:0] gap_q;
  logic       seen_q;
  assign acc_w = psel && penable && pwrite;
  assign acc_r = psel && penable && !pwrite;
  assign wbyte = pwdata[7:0];
  // command window and auto-reload entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q  <= 3'h0;
      auto_q <= 1'b0;
    end else if (acc_w && paddr == ADDR_COMMAND) begin
      win_q <= (wbyte == 8'h80) ? 3'h4 : 3'h0;
      if (win_q != 3'h0 && wbyte == {4'h0, CMD_WD_AUTO})
        auto_q <= 1'b1;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end
  end
  // cycles since the last divider unlock write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_q <= 4'hF;
    else if (acc_w && paddr == ADDR_DIVIDER && wbyte == 8'h80)
      since_q <= 4'h0;
    else if (since_q != 4'hF)
      since_q <= since_q + 4'h1;
  end
  // spacing of clock enable pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q  <= 10'h0;
      seen_q <= 1'b0;
    end else if (sys_clk_en) begin
      gap_q  <= 10'h1;
      seen_q <= 1'b1;
    end else if (gap_q != 10'h3FF) begin
      gap_q <= gap_q + 10'h1;
    end
  end
  // ----------------
  // assertions
  // ----------------
  AST_TRIM_WR: assert property (
    acc_w && paddr == ADDR_TRIM |=> rc_trim_out == $past(wbyte)
  ) else $error("trim output not loaded by write");
  AST_TRIM_HOLD: assert property (
    !(acc_w && paddr == ADDR_TRIM) |=> $stable(rc_trim_out)
  ) else $error("trim output moved without write");
  AST_NO_IRQ: assert property (
    auto_q |=> !wdog_irq
  ) else $error("interrupt raised in auto-reload mode");
  AST_AUTO_STICKY: assert property (
    acc_r && paddr == ADDR_STATUS |-> prdata[4] == auto_q
  ) else $error("auto-reload status wrong");
  AST_DIV_RSV: assert property (
    acc_r && paddr == ADDR_DIVIDER |-> prdata[6:4] == 3'h0
  ) else $error("divider reserved bits not zero");
  AST_DIV_LOCKED: assert property (
    acc_r && paddr == ADDR_DIVIDER && since_q > 4'h6 |-> !prdata[7]
  ) else $error("divider unlock outlived its window");
  AST_STATUS_RANGE: assert property (
    acc_r && paddr == ADDR_STATUS |-> prdata[3:0] <= DIV_CODE_MAX
  ) else $error("reserved divider code became active");
  AST_CLK_GAP: assert property (
    sys_clk_en && seen_q |-> gap_q <= 10'h100
  ) else $error("clock enable period above 256");
  cover property (auto_q && wd_osc_tick);
  cover property (acc_w && paddr == ADDR_DIVIDER && since_q < 4'h4);
  cover property (sys_clk_en && seen_q && gap_q == 10'h100);
endmodule
bind clk_ctrl clk_ctrl_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .divide_by_eight_fuse(divide_by_eight_fuse),
  .wd_osc_tick(wd_osc_tick), .sys_clk_en(sys_clk_en),
  .rc_trim_out(rc_trim_out), .wdog_reset_req(wdog_reset_req),
  .wdog_irq(wdog_irq)
);

//--- bench/tb.sv
/*
 self-checking bench for clk_ctrl: divider code table, then unlock
 timing, unmapped access, trim, auto-reload and reset cases.
 assumes the checker binds itself to clk_ctrl.
*/
`timescale 1ns/10ps
module tb
  import clk_ctrl_pkg::*;
;
  typedef struct packed {
    logic [3:0]  code;
    logic [3:0]  act;
    logic [31:0] fac;
  } row_s;
  localparam logic [7:0] TRIM_INIT = 8'hA5;
  localparam row_s ROWS [10] = '{
    '{4'h0, 4'h0, 32'h1}, '{4'h1, 4'h1, 32'h2}, '{4'h2, 4'h2, 32'h4},
    '{4'h3, 4'h3, 32'h8}, '{4'h4, 4'h4, 32'h10}, '{4'h5, 4'h5, 32'h20},
    '{4'h6, 4'h6, 32'h40}, '{4'h7, 4'h7, 32'h80},
    '{4'h8, 4'h8, 32'h100}, '{4'h9, 4'h8, 32'h100}};
  localparam logic [7:0] TV [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        fuse, tick, clk_en, wd_rst, wd_irq, err_bit;
  logic [7:0]  paddr, trim;
  logic [31:0] pwdata, prdata, rd, g;
  int          err_count;
  int          tests_run;

  always #4 pclk = ~pclk;

  clk_ctrl #(.FACTORY_TRIM(TRIM_INIT)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .divide_by_eight_fuse(fuse),
    .wd_osc_tick(tick), .sys_clk_en(clk_en), .rc_trim_out(trim),
    .wdog_reset_req(wd_rst), .wdog_irq(wd_irq));
  // ----------------
  // tasks
  // ----------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, x);
    tests_run++;
    if (x !== e) begin
      err_count++;
      $display("FAIL %s exp %h got %h", nm, e, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input int idle);
    int n;
    repeat (idle + 1) @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_count++;
      print_verdict();
    end
    rd = prdata;
    err_bit = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input int idle = 0);
    apb(1'b1, a, d, idle);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0, 0);
    chk(nm, e, rd);
  endtask
  // cycles between two clock enable pulses
  task automatic gap();
    int n;
    n = 0;
    g = 32'h0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (clk_en !== 1'b1 && n < 600);
    do begin
      @(posedge pclk);
      #1;
      n++;
      g++;
    end while (clk_en !== 1'b1 && n < 1200);
    if (n >= 1200) begin
      err_count++;
      print_verdict();
    end
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, tick} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fuse = 1'b1;
    err_count = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(ADDR_DIVIDER, 32'h3, "div rst");
    rdchk(ADDR_TRIM, {24'h0, TRIM_INIT}, "trim rst");
    gap();
    gap();
    chk("period rst", 32'h8, g);
    foreach (ROWS[i]) begin
      wr(ADDR_DIVIDER, 32'h80);
      wr(ADDR_DIVIDER, {28'h0, ROWS[i].code});
      rdchk(ADDR_DIVIDER, {28'h0, ROWS[i].code}, "div");
      gap();
      gap();
      chk("period", ROWS[i].fac, g);
      rdchk(ADDR_STATUS, {28'h0, ROWS[i].act}, "act");
    end
    wr(ADDR_DIVIDER, 32'h80);
    rdchk(ADDR_DIVIDER, 32'h89, "unlock set");
    wr(ADDR_DIVIDER, 32'h2);
    rdchk(ADDR_DIVIDER, 32'h9, "late write");
    wr(ADDR_DIVIDER, 32'h80);
    wr(ADDR_DIVIDER, 32'h2, 1);
    rdchk(ADDR_DIVIDER, 32'h2, "edge four");
    wr(ADDR_DIVIDER, 32'h80);
    wr(ADDR_DIVIDER, 32'h5, 2);
    rdchk(ADDR_DIVIDER, 32'h2, "edge five");
    wr(ADDR_DIVIDER, 32'h81);
    wr(ADDR_DIVIDER, 32'h4);
    rdchk(ADDR_DIVIDER, 32'h2, "bad unlock");
    wr(ADDR_DIVIDER, 32'h80);
    wr(ADDR_DIVIDER, 32'h80);
    wr(ADDR_DIVIDER, 32'h6, 1);
    rdchk(ADDR_DIVIDER, 32'h2, "no restart");
    wr(ADDR_DIVIDER, 32'h80);
    wr(ADDR_DIVIDER, 32'h73);
    rdchk(ADDR_DIVIDER, 32'h3, "rsv bits");
    apb(1'b0, 8'h40, 32'h0, 0);
    chk("slverr", 32'h1, {31'h0, err_bit});
    chk("unmapped", 32'h0, rd);
    foreach (TV[i]) begin
      wr(ADDR_TRIM, {24'h0, TV[i]});
      rdchk(ADDR_TRIM, {24'h0, TV[i]}, "trim");
      chk("trim pin", {24'h0, TV[i]}, {24'h0, trim});
    end
    wr(ADDR_DIVIDER, 32'h80);
    wr(ADDR_DIVIDER, 32'h0);
    wr(ADDR_WDOG, 32'h98);
    wr(ADDR_WDOG, 32'h18);
    wr(ADDR_COMMAND, 32'h80);
    wr(ADDR_COMMAND, {28'h0, CMD_WD_AUTO});
    apb(1'b0, ADDR_STATUS, 32'h0, 0);
    chk("auto on", 32'h10, rd & 32'h10);
    err_bit = 1'b0;
    // tick every four cycles: 2500 ticks would expire the plain watchdog
    for (int k = 0; k < 10000; k++) begin
      @(posedge pclk);
      if (k[0])
        tick <= ~tick;
      #1;
      if (wd_irq === 1'b1 || wd_rst === 1'b1)
        err_bit = 1'b1;
    end
    chk("wdog quiet", 32'h0, {31'h0, err_bit});
    wr(ADDR_COMMAND, 32'h80);
    wr(ADDR_COMMAND, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0, 0);
    chk("auto kept", 32'h10, rd & 32'h10);
    fuse <= 1'b0;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0, 0);
    chk("auto clr", 32'h0, rd & 32'h10);
    rdchk(ADDR_DIVIDER, 32'h0, "div nofuse");
    chk("trim rst2", {24'h0, TRIM_INIT}, {24'h0, trim});
    print_verdict();
  end
endmodule
